// [inc/bia_pkg.sv]
package bia_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned ONE_SEC_S = 1;
  localparam int unsigned ONE_SEC_CYC = ONE_SEC_S * CLK_HZ;

  // ----------------------------------------------------------------
  // Processor port geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int OFS_W = 12;
  localparam int CHAN_W = 4;

  // ----------------------------------------------------------------
  // Per-channel offsets (channel number forms the top nibble)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_LOOPBACK_CODE_PENDING = 12'hb0a;
  localparam logic [11:0] OFS_HDLC0 = 12'hb06;
  localparam logic [11:0] OFS_HDLC1 = 12'hb16;
  localparam logic [11:0] OFS_HDLC2 = 12'hb26;
  localparam logic [11:0] OFS_HDLC0_ALT = 12'hb10;
  localparam logic [11:0] OFS_HDLC1_ALT = 12'hb18;
  localparam logic [11:0] OFS_HDLC2_ALT = 12'hb28;
  localparam logic [11:0] OFS_SLIP = 12'hb08;
  localparam logic [11:0] OFS_ALARM0 = 12'hb02;
  localparam logic [11:0] OFS_ALARM1 = 12'hb0e;
  localparam logic [11:0] OFS_ALARM2 = 12'hb40;
  localparam logic [11:0] OFS_FRAMER = 12'hb04;
  localparam logic [11:0] OFS_CLK_CFG = 12'h100;
  localparam logic [11:0] OFS_SUMMARY = 12'hbe0;
  localparam logic [11:0] OFS_IRQ_STAT = 12'hbe1;
  localparam logic [11:0] OFS_IRQ_EN = 12'hbe2;
  localparam logic [11:0] OFS_IRQ_CLR = 12'hbe3;

  // ----------------------------------------------------------------
  // Summary register bit positions
  // ----------------------------------------------------------------
  localparam int SUM_RSVD = 7;
  localparam int SUM_LOOPBACK_CODE_PENDING = 6;
  localparam int SUM_CLKLOSS = 5;
  localparam int SUM_ONE_SECOND_TICK_FLAG = 4;
  localparam int SUM_HDLC = 3;
  localparam int SUM_SLIP = 2;
  localparam int SUM_ALARM = 1;
  localparam int SUM_FRAMER = 0;
  localparam int N_EVT = 7;

  // ----------------------------------------------------------------
  // Internal pending-flag vector layout
  // ----------------------------------------------------------------
  localparam int N_HDLC = 3;
  localparam int N_ALARM = 3;
  localparam int FL_LOOPBACK_CODE_PENDING = 0;
  localparam int FL_CLKLOSS = 1;
  localparam int FL_ONE_SECOND_TICK_FLAG = 2;
  localparam int FL_HDLC = 3;
  localparam int FL_SLIP = 6;
  localparam int FL_ALARM = 7;
  localparam int FL_FRAMER = 10;
  localparam int N_FLAGS = 11;

  // ----------------------------------------------------------------
  // Configuration fields and reset values
  // ----------------------------------------------------------------
  localparam int CFG_CLK_LOSS_EN_BIT = 0;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic CLK_LOSS_EN_RST = 1'b0;
  localparam logic [6:0] IRQ_EN_RST = 7'h00;

  // Request pulses from the functional blocks of one channel
  typedef struct packed {
    logic loopback_code_pending;
    logic clk_loss;
    logic [2:0] hdlc;
    logic slip;
    logic [2:0] alarm;
    logic framer;
  } bia_src_t;

endpackage

// [design/bia_sticky.sv]
module bia_sticky
  import bia_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Flag control
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clr,
  // Flags
  output logic [W-1:0] o_flag
);

  typedef struct packed {
    logic [W-1:0] flag;
  } bia_sticky_st_t;

  bia_sticky_st_t st_q;
  bia_sticky_st_t st_d;

  // Set beats clear so an event in the clearing cycle survives
  always_comb begin
    st_d = st_q;
    st_d.flag = (st_q.flag & ~i_clr) | i_set;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_flag = st_q.flag;

endmodule

// [design/bia_tick_gen.sv]
module bia_tick_gen
  import bia_pkg::*;
#(
  parameter int unsigned PERIOD = ONE_SEC_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Tick
  output logic o_tick
);

  localparam int CNT_W = (PERIOD > 1) ? $clog2(PERIOD) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PERIOD - 1);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } bia_tick_st_t;

  bia_tick_st_t st_q;
  bia_tick_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.cnt == CNT_LAST) begin
      st_d.cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_tick = st_q.tick;

endmodule

// [design/bia_block_irq_summary.sv]
// Added by the designer: the placing of the registers and the strobed register port.
module bia_block_irq_summary
  import bia_pkg::*;
#(
  parameter logic [CHAN_W-1:0] CHAN_ID = 4'h0,
  parameter int unsigned TICK_CYCLES = ONE_SEC_CYC
) (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_ARST_N,
  // Processor port
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [DATA_W-1:0] O_RDATA,
  // Functional block requests
  input wire bia_src_t I_SRC,
  // Summary and interrupt
  output logic [DATA_W-1:0] O_SUMMARY,
  output logic O_IRQ
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [OFS_W-1:0] ofs);
    return a == {CHAN_ID, ofs};
  endfunction

  // Folds the per-source pending flags into the summary byte
  function automatic logic [DATA_W-1:0] fold_summary(input logic [N_FLAGS-1:0] f);
    logic [DATA_W-1:0] s;
    s = '0;
    s[SUM_LOOPBACK_CODE_PENDING] = f[FL_LOOPBACK_CODE_PENDING];
    s[SUM_CLKLOSS] = f[FL_CLKLOSS];
    s[SUM_ONE_SECOND_TICK_FLAG] = f[FL_ONE_SECOND_TICK_FLAG];
    s[SUM_HDLC] = |f[FL_HDLC +: N_HDLC];
    s[SUM_SLIP] = f[FL_SLIP];
    s[SUM_ALARM] = |f[FL_ALARM +: N_ALARM];
    s[SUM_FRAMER] = f[FL_FRAMER];
    s[SUM_RSVD] = 1'b0;
    return s;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] summary;
    logic clk_loss_en;
    logic [N_EVT-1:0] irq_en;
    logic irq;
  } bia_top_st_t;

  bia_top_st_t st_q;
  bia_top_st_t st_d;

  logic one_sec_tick;
  logic [N_FLAGS-1:0] flag_q;
  logic [N_FLAGS-1:0] flag_set;
  logic [N_FLAGS-1:0] flag_clr;
  logic [N_EVT-1:0] evt_q;
  logic [N_EVT-1:0] evt_set;
  logic [N_EVT-1:0] evt_clr;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic rd_loopback_code_pending;
  logic rd_slip;
  logic rd_framer;
  logic rd_summary;
  logic [N_HDLC-1:0] rd_hdlc;
  logic [N_ALARM-1:0] rd_alarm;
  logic wr_cfg;
  logic wr_irq_en;
  logic wr_irq_clr;

  always_comb begin
    rd_loopback_code_pending = I_RD && addr_hit(I_ADDR, OFS_LOOPBACK_CODE_PENDING);
    rd_slip = I_RD && addr_hit(I_ADDR, OFS_SLIP);
    rd_framer = I_RD && addr_hit(I_ADDR, OFS_FRAMER);
    rd_summary = I_RD && addr_hit(I_ADDR, OFS_SUMMARY);
    // Each controller answers at a primary and a secondary status address
    rd_hdlc[0] = I_RD && (addr_hit(I_ADDR, OFS_HDLC0) || addr_hit(I_ADDR, OFS_HDLC0_ALT));
    rd_hdlc[1] = I_RD && (addr_hit(I_ADDR, OFS_HDLC1) || addr_hit(I_ADDR, OFS_HDLC1_ALT));
    rd_hdlc[2] = I_RD && (addr_hit(I_ADDR, OFS_HDLC2) || addr_hit(I_ADDR, OFS_HDLC2_ALT));
    rd_alarm[0] = I_RD && addr_hit(I_ADDR, OFS_ALARM0);
    rd_alarm[1] = I_RD && addr_hit(I_ADDR, OFS_ALARM1);
    rd_alarm[2] = I_RD && addr_hit(I_ADDR, OFS_ALARM2);
    wr_cfg = I_WR && addr_hit(I_ADDR, OFS_CLK_CFG);
    wr_irq_en = I_WR && addr_hit(I_ADDR, OFS_IRQ_EN);
    wr_irq_clr = I_WR && addr_hit(I_ADDR, OFS_IRQ_CLR);
  end

  // ----------------------------------------------------------------
  // One-second timebase
  // ----------------------------------------------------------------
  bia_tick_gen #(
    .PERIOD(TICK_CYCLES)
  ) u_tick (
    .i_clk(I_CLK_SYS),
    .i_arst_n(I_ARST_N),
    .o_tick(one_sec_tick)
  );

  // ----------------------------------------------------------------
  // Pending flags per source
  // ----------------------------------------------------------------
  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[FL_LOOPBACK_CODE_PENDING] = I_SRC.loopback_code_pending;
    flag_clr[FL_LOOPBACK_CODE_PENDING] = rd_loopback_code_pending;
    // Loss events are dropped, and any stale flag wiped, while detection is off
    flag_set[FL_CLKLOSS] = I_SRC.clk_loss && st_q.clk_loss_en;
    flag_clr[FL_CLKLOSS] = rd_summary || !st_q.clk_loss_en;
    flag_set[FL_ONE_SECOND_TICK_FLAG] = one_sec_tick;
    flag_clr[FL_ONE_SECOND_TICK_FLAG] = rd_summary;
    flag_set[FL_HDLC +: N_HDLC] = I_SRC.hdlc;
    flag_clr[FL_HDLC +: N_HDLC] = rd_hdlc;
    flag_set[FL_SLIP] = I_SRC.slip;
    flag_clr[FL_SLIP] = rd_slip;
    flag_set[FL_ALARM +: N_ALARM] = I_SRC.alarm;
    flag_clr[FL_ALARM +: N_ALARM] = rd_alarm;
    flag_set[FL_FRAMER] = I_SRC.framer;
    flag_clr[FL_FRAMER] = rd_framer;
  end

  bia_sticky #(
    .W(N_FLAGS)
  ) u_pending (
    .i_clk(I_CLK_SYS),
    .i_arst_n(I_ARST_N),
    .i_set(flag_set),
    .i_clr(flag_clr),
    .o_flag(flag_q)
  );

  // ----------------------------------------------------------------
  // Interrupt event status
  // ----------------------------------------------------------------
  // Any new request on a summary bit latches its event bit, except clock loss while detection is off
  always_comb begin
    logic [DATA_W-1:0] s;
    s = fold_summary(flag_set);
    evt_set = s[N_EVT-1:0];
    evt_clr = wr_irq_clr ? I_WDATA[N_EVT-1:0] : '0;
  end

  bia_sticky #(
    .W(N_EVT)
  ) u_events (
    .i_clk(I_CLK_SYS),
    .i_arst_n(I_ARST_N),
    .i_set(evt_set),
    .i_clr(evt_clr),
    .o_flag(evt_q)
  );

  // ----------------------------------------------------------------
  // Registers, read data and outputs
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.rdata = '0;
    st_d.summary = fold_summary(flag_q);
    if (wr_cfg) begin
      st_d.clk_loss_en = I_WDATA[CFG_CLK_LOSS_EN_BIT];
    end
    if (wr_irq_en) begin
      st_d.irq_en = I_WDATA[N_EVT-1:0];
    end
    // Summary writes fall through every decode and change nothing
    if (I_RD) begin
      if (addr_hit(I_ADDR, OFS_SUMMARY)) begin
        // Value before this read's clear
        st_d.rdata = fold_summary(flag_q);
      end else if (addr_hit(I_ADDR, OFS_CLK_CFG)) begin
        st_d.rdata[CFG_CLK_LOSS_EN_BIT] = st_q.clk_loss_en;
      end else if (addr_hit(I_ADDR, OFS_IRQ_STAT)) begin
        st_d.rdata[N_EVT-1:0] = evt_q;
      end else if (addr_hit(I_ADDR, OFS_IRQ_EN)) begin
        st_d.rdata[N_EVT-1:0] = st_q.irq_en;
      end else begin
        st_d.rdata = '0;
      end
    end
    st_d.irq = |(evt_q & st_q.irq_en);
  end

  always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      st_q.rdata <= RDATA_RST;
      st_q.summary <= RDATA_RST;
      st_q.clk_loss_en <= CLK_LOSS_EN_RST;
      st_q.irq_en <= IRQ_EN_RST;
      st_q.irq <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign O_RDATA = st_q.rdata;
  assign O_SUMMARY = st_q.summary;
  assign O_IRQ = st_q.irq;

endmodule

// [tb/bia_props.sv]
module bia_props
  import bia_pkg::*;
#(
  parameter logic [CHAN_W-1:0] CHAN_ID = 4'h0,
  parameter int unsigned TICK_CYCLES = ONE_SEC_CYC
) (
  // Clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_ARST_N,
  // Processor port
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [DATA_W-1:0] O_RDATA,
  // Requests and outputs
  input wire bia_src_t I_SRC,
  input wire logic [DATA_W-1:0] O_SUMMARY,
  input wire logic O_IRQ
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_ARST_N);
  wire rd_sum = I_RD && I_ADDR == {CHAN_ID, OFS_SUMMARY};
  wire rd_slip = I_RD && I_ADDR == {CHAN_ID, OFS_SLIP};
  wire rd_frm = I_RD && I_ADDR == {CHAN_ID, OFS_FRAMER};
  wire rd_lb = I_RD && I_ADDR == {CHAN_ID, OFS_LOOPBACK_CODE_PENDING};
  // ----------------------------------------------------------------
  // Summary timing: set shows two edges on, a set wins over a read
  // ----------------------------------------------------------------
  rsvd_zero_a: assert property (!O_SUMMARY[SUM_RSVD]) else $error("bit 7 set");
  lb_set_a: assert property (I_SRC.loopback_code_pending |-> ##2 O_SUMMARY[SUM_LOOPBACK_CODE_PENDING]) else $error("lb not set");
  lb_clr_a: assert property (rd_lb && !I_SRC.loopback_code_pending |-> ##2 !O_SUMMARY[SUM_LOOPBACK_CODE_PENDING]) else $error("lb kept");
  loss_clr_a: assert property (rd_sum && !I_SRC.clk_loss |-> ##2 !O_SUMMARY[SUM_CLKLOSS])
    else $error("loss kept");
  sum_read_a: assert property (rd_sum |=> O_RDATA == O_SUMMARY) else $error("read differs");
  hdlc_set_a: assert property (|I_SRC.hdlc |-> ##2 O_SUMMARY[SUM_HDLC]) else $error("hdlc not set");
  slip_set_a: assert property (I_SRC.slip |-> ##2 O_SUMMARY[SUM_SLIP]) else $error("slip not set");
  slip_clr_a: assert property (rd_slip && !I_SRC.slip |-> ##2 !O_SUMMARY[SUM_SLIP]) else $error("slip kept");
  alarm_set_a: assert property (|I_SRC.alarm |-> ##2 O_SUMMARY[SUM_ALARM]) else $error("alarm not set");
  frm_clr_a: assert property (rd_frm && !I_SRC.framer |-> ##2 !O_SUMMARY[SUM_FRAMER]) else $error("frm kept");
  frm_set_a: assert property (I_SRC.framer |-> ##2 O_SUMMARY[SUM_FRAMER]) else $error("frm not set");
  cover property (O_SUMMARY[SUM_SLIP] ##0 rd_slip ##2 !O_SUMMARY[SUM_SLIP]);
  cover property (I_SRC.clk_loss ##2 O_SUMMARY[SUM_CLKLOSS]);
  cover property ($rose(O_IRQ));
endmodule

bind bia_block_irq_summary bia_props #(.CHAN_ID(CHAN_ID), .TICK_CYCLES(TICK_CYCLES)) u_props (
  .I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
  .I_RD(I_RD), .O_RDATA(O_RDATA), .I_SRC(I_SRC), .O_SUMMARY(O_SUMMARY), .O_IRQ(O_IRQ));

// [tb/tb_bia_block_irq_summary.sv]
module tb_bia_block_irq_summary;
  import bia_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] CH = 4'h3;
  localparam int TK = 200;
  logic clk, arst_n, wr, rd, irq, en;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, summary, rdat, osum, ex;
  logic [9:0] rv;
  bia_src_t src, m;
  int fails, n_compared, seed, cyc, i, k;
  logic [11:0] tbl [12] = '{OFS_LOOPBACK_CODE_PENDING, OFS_HDLC0, OFS_HDLC1, OFS_HDLC2, OFS_HDLC0_ALT, OFS_HDLC1_ALT,
    OFS_HDLC2_ALT, OFS_SLIP, OFS_ALARM0, OFS_ALARM1, OFS_ALARM2, OFS_FRAMER};

  bia_block_irq_summary #(.CHAN_ID(CH), .TICK_CYCLES(TK)) dut (
    .I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_SRC(src), .O_SUMMARY(summary), .O_IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Expectation and bus tasks
  // ----------------------------------------------------------------
  function automatic logic [7:0] exp_sum();
    return {1'b0, m.loopback_code_pending, m.clk_loss, 1'b0, |m.hdlc, m.slip, |m.alarm, m.framer};
  endfunction
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One strobe cycle, requests pulsed in the same cycle; the model clears first so a set wins
  task automatic bus(logic w, logic r, logic [11:0] o, logic [7:0] d, bia_src_t s);
    ex = exp_sum();
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= {CH, o};
    wdata <= d;
    src <= s;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    src <= '0;
    #1 rdat = rdata;
    osum = summary;
    if (r) case (o)
      OFS_LOOPBACK_CODE_PENDING: m.loopback_code_pending = 1'b0;
      OFS_HDLC0, OFS_HDLC0_ALT: m.hdlc[0] = 1'b0;
      OFS_HDLC1, OFS_HDLC1_ALT: m.hdlc[1] = 1'b0;
      OFS_HDLC2, OFS_HDLC2_ALT: m.hdlc[2] = 1'b0;
      OFS_SLIP: m.slip = 1'b0;
      OFS_ALARM0: m.alarm[0] = 1'b0;
      OFS_ALARM1: m.alarm[1] = 1'b0;
      OFS_ALARM2: m.alarm[2] = 1'b0;
      OFS_FRAMER: m.framer = 1'b0;
      OFS_SUMMARY: m.clk_loss = 1'b0;
      default: ;
    endcase
    if (w && o == OFS_CLK_CFG) begin
      en = d[0];
      m.clk_loss = m.clk_loss & en;
    end
    s.clk_loss = s.clk_loss & en;
    m = m | s;
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {arst_n, wr, rd, addr, wdata, src, m, en, rdat} = '0;
    seed = 81;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    bus(0, 1, OFS_SUMMARY, 8'h00, '0);
    chk("summary reset", 8'h00, rdat);
    bus(0, 1, OFS_CLK_CFG, 8'h00, '0);
    chk("clk cfg reset", 8'h00, rdat);
    bus(0, 1, 12'h7ff, 8'h00, '0);
    chk("unmapped", 8'h00, rdat);
    $display("test reset done");
    for (i = 0; i < 300; i++) begin
      if (i == 100 || i == 200) bus(1, 0, OFS_CLK_CFG, {7'h00, i == 100}, '0);
      if (i == 100) begin
        bus(0, 1, OFS_CLK_CFG, 8'h00, '0);
        chk("clk cfg set", 8'h01, rdat);
      end
      if (i == 150) bus(1, 0, OFS_SUMMARY, 8'hff, '0);
      rv = 10'($random(seed) & $random(seed) & $random(seed));
      k = $unsigned($random(seed)) % 12;
      bus(0, 1, tbl[k], 8'h00, rv);
      bus(0, 1, OFS_SUMMARY, 8'h00, '0);
      chk("summary", ex & 8'hef, rdat & 8'hef);
      chk("summary pin", ex & 8'hef, osum & 8'hef);
    end
    $display("test sources done");
    bus(1, 0, OFS_IRQ_CLR, 8'h7f, '0);
    bus(1, 0, OFS_IRQ_EN, 8'h04, '0);
    bus(0, 1, OFS_IRQ_EN, 8'h00, '0);
    chk("irq enable", 8'h04, rdat);
    bus(0, 0, OFS_SUMMARY, 8'h00, 10'h001);
    @(posedge clk);
    #1 chk("irq masked", 8'h00, {7'h00, irq});
    chk("rdata idle", 8'h00, rdata);
    bus(0, 1, OFS_IRQ_STAT, 8'h00, '0);
    chk("irq status", 8'h01, rdat & 8'hef);
    bus(0, 0, OFS_SUMMARY, 8'h00, 10'h010);
    @(posedge clk);
    #1 chk("irq raised", 8'h01, {7'h00, irq});
    bus(1, 0, OFS_IRQ_CLR, 8'h04, '0);
    @(posedge clk);
    #1 chk("irq cleared", 8'h00, {7'h00, irq});
    $display("test irq done");
    rdat = '0;
    for (k = 0; k < 3 * TK && rdat[4] !== 1'b1; k++) bus(0, 1, OFS_SUMMARY, 8'h00, '0);
    chk("tick seen", 8'h10, rdat & 8'h10);
    bus(0, 1, OFS_SUMMARY, 8'h00, '0);
    chk("tick cleared", 8'h00, rdat & 8'h10);
    repeat (TK - 12) @(posedge clk);
    bus(0, 1, OFS_SUMMARY, 8'h00, '0);
    chk("tick early", 8'h00, rdat & 8'h10);
    repeat (16) @(posedge clk);
    bus(0, 1, OFS_SUMMARY, 8'h00, '0);
    chk("tick again", 8'h10, rdat & 8'h10);
    $display("test tick done");
    close_out();
  end
endmodule
